// ---- rtl/pbc_top.sv ----
// Playback channel update control: APB registers, per-channel strobe engines,
// DVR/frame format conversion controls and record mode selection.
// Assumes decoded channel ID strobes come from on-chip logic on mclk; the
// cascade link pin is an external pin and is synchronised before use.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pbc_top
	import pbc_pkg::*;
#(
	parameter int NCH = PBC_NCH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic id_valid,
	input wire logic [PBC_IDW-1:0] id_ch,
	input wire logic id_event,
	input wire logic id_frame,
	input wire logic id_odd,
	input wire logic [23:0] rec_rt_data,
	input wire logic [7:0] cascade_link_in_i,
	output logic [7:0] cascade_link_in_o,
	output logic cascade_link_in_oe,
	output logic [15:0] multipurpose_pins_o,
	output logic multipurpose_pins_oe,
	output logic [NCH-1:0] ch_update,
	output logic [NCH-1:0] ch_bypass,
	output logic [NCH-1:0] ch_auto_crop,
	output logic [NCH-1:0] ch_field_route,
	output logic [NCH-1:0] ch_dvr_normal_conv,
	output logic [NCH-1:0] ch_dvr_frame_conv,
	output logic [NCH-1:0] ch_quarter_crop,
	output logic [NCH-1:0] ch_vscale_off,
	output logic [NCH-1:0] ch_odd_only,
	output logic [NCH-1:0] ch_full_image,
	output logic hzoom_only,
	output logic [1:0] rec_mode,
	output logic [1:0] rec_size
);
	logic [PBC_G_W-1:0] glob_q;
	logic [PBC_C_W-1:0] chctl_q [NCH];
	logic [NCH-1:0] upd;
	logic [NCH-1:0] frz;
	logic [PBC_CNT_W-1:0] cnt [NCH];
	logic [7:0] link_s1_q;
	logic [7:0] link_s2_q;
	logic wr_en;
	logic rd_en;

	// Index of a per-channel register, or NCH when the address misses the bank
	function automatic int unsigned ch_index(input logic [7:0] addr, input logic [7:0] base);
		int unsigned idx;
		idx = NCH;
		for (int unsigned i = 0; i < NCH; i++) begin
			if (addr == base + 8'(i * PBC_OFS_STEP)) begin
				idx = i;
			end
		end
		return idx;
	endfunction

	function automatic logic [1:0] mode_of(input logic [PBC_C_W-1:0] c);
		return c[PBC_C_MODE +: 2];
	endfunction

	// One wait state: pready rises in the second access cycle
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && penable && !pready && !pwrite;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && penable && !pready && (paddr[1:0] != 2'h0 ||
				(paddr != PBC_OFS_GLOBAL && paddr != PBC_OFS_LINK &&
				ch_index(paddr, PBC_OFS_CHCTL0) == NCH &&
				ch_index(paddr, PBC_OFS_CHSTA0) == NCH));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= '0;
		end else if (rd_en) begin
			prdata <= '0;
			if (paddr == PBC_OFS_GLOBAL) begin
				prdata <= 32'(glob_q);
			end else if (paddr == PBC_OFS_LINK) begin
				prdata <= 32'(link_s2_q);
			end else if (ch_index(paddr, PBC_OFS_CHCTL0) < NCH) begin
				prdata <= 32'(chctl_q[ch_index(paddr, PBC_OFS_CHCTL0)]);
			end else if (ch_index(paddr, PBC_OFS_CHSTA0) < NCH) begin
				prdata <= {16'h0000, cnt[ch_index(paddr, PBC_OFS_CHSTA0)], 7'h00,
					frz[ch_index(paddr, PBC_OFS_CHSTA0)]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			glob_q <= PBC_G_RST;
		end else if (wr_en && paddr == PBC_OFS_GLOBAL) begin
			glob_q <= pwdata[PBC_G_W-1:0];
		end
	end

	// Decoder reload of the select field wins over a software write in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				chctl_q[i] <= PBC_C_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_en && ch_index(paddr, PBC_OFS_CHCTL0) == i) begin
					chctl_q[i] <= pwdata[PBC_C_W-1:0];
				end
				if (id_valid && chctl_q[i][PBC_C_PBSRC] && !glob_q[PBC_G_AUTO] &&
					mode_of(chctl_q[i]) == PBC_MODE_LIVE) begin
					chctl_q[i][PBC_C_SEL +: PBC_IDW] <= id_ch;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			pbc_chan_unit u_chan (
				.mclk(mclk),
				.rst(rst),
				.mode(mode_of(chctl_q[g])),
				.sel(chctl_q[g][PBC_C_SEL +: PBC_IDW]),
				.auto_en(glob_q[PBC_G_AUTO]),
				.event_en(chctl_q[g][PBC_C_EVENT]),
				.freeze(chctl_q[g][PBC_C_FREEZE]),
				.f2f(chctl_q[g][PBC_C_F2F]),
				.id_valid(id_valid && chctl_q[g][PBC_C_PBSRC]),
				.id_ch(id_ch),
				.id_event(id_event),
				.id_frame(id_frame),
				.id_odd(id_odd),
				.update_q(upd[g]),
				.frozen_q(frz[g]),
				.count_q(cnt[g])
			);

			property p_sel_reload;
				@(posedge mclk) disable iff (rst)
				id_valid && chctl_q[g][PBC_C_PBSRC] && !glob_q[PBC_G_AUTO] &&
					mode_of(chctl_q[g]) == PBC_MODE_LIVE |=>
					chctl_q[g][PBC_C_SEL +: PBC_IDW] == $past(id_ch);
			endproperty
			a_sel_reload: assert property (p_sel_reload) else $error("no reload");

			property p_bypass;
				@(posedge mclk) disable iff (rst)
				chctl_q[g][PBC_C_PBSRC] && mode_of(chctl_q[g]) == PBC_MODE_LIVE |=>
					ch_bypass[g] && ch_auto_crop[g];
			endproperty
			a_bypass: assert property (p_bypass) else $error("not bypassed");

			property p_field_route;
				@(posedge mclk) disable iff (rst)
				chctl_q[g][PBC_C_SPLIT] && chctl_q[g][PBC_C_HALF] |=> ch_field_route[g];
			endproperty
			a_field_route: assert property (p_field_route) else $error("no routing");
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			ch_update <= '0;
		end else begin
			ch_update <= upd;
		end
	end

	// Display format controls, one flop stage behind the registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ch_bypass <= '0;
			ch_auto_crop <= '0;
			ch_field_route <= '0;
			ch_dvr_normal_conv <= '0;
			ch_dvr_frame_conv <= '0;
			ch_quarter_crop <= '0;
			ch_vscale_off <= '0;
			ch_odd_only <= '0;
			ch_full_image <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				ch_bypass[i] <= chctl_q[i][PBC_C_PBSRC] &&
					mode_of(chctl_q[i]) == PBC_MODE_LIVE;
				ch_auto_crop[i] <= chctl_q[i][PBC_C_PBSRC] &&
					mode_of(chctl_q[i]) == PBC_MODE_LIVE;
				// Split replaces the half vertical scaler only at half height
				ch_field_route[i] <= chctl_q[i][PBC_C_SPLIT] && chctl_q[i][PBC_C_HALF];
				ch_dvr_normal_conv[i] <= chctl_q[i][PBC_C_DVR] && !chctl_q[i][PBC_C_SPLIT];
				ch_dvr_frame_conv[i] <= chctl_q[i][PBC_C_DVR] && chctl_q[i][PBC_C_SPLIT];
				ch_quarter_crop[i] <= chctl_q[i][PBC_C_DVR] && glob_q[PBC_G_QCROP];
				// DVR input has a fixed quad picture, so the vertical scaler is off
				ch_vscale_off[i] <= chctl_q[i][PBC_C_DVR];
				ch_odd_only[i] <= chctl_q[i][PBC_C_DVR] && chctl_q[i][PBC_C_SPLIT] &&
					chctl_q[i][PBC_C_SMALL];
				ch_full_image[i] <= chctl_q[i][PBC_C_DVR] && glob_q[PBC_G_HZOOM];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hzoom_only <= 1'b0;
		end else begin
			hzoom_only <= glob_q[PBC_G_HZOOM];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rec_mode <= PBC_REC_NORMAL;
		end else begin
			rec_mode <= {glob_q[PBC_G_RFRAME], glob_q[PBC_G_RSTREAM]};
		end
	end

	// Free size codes are not offered in record; an illegal code falls back to quad
	always_ff @(posedge mclk) begin
		if (rst) begin
			rec_size <= PBC_RSZ_FULL;
		end else begin
			case (glob_q[PBC_G_RSIZE +: 2])
				PBC_RSZ_FULL: rec_size <= PBC_RSZ_FULL;
				PBC_RSZ_CIF: rec_size <= PBC_RSZ_CIF;
				default: rec_size <= PBC_RSZ_QUAD;
			endcase
		end
	end

	// Real-time D1 record: link input and multipurpose pins turn into record outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			cascade_link_in_o <= '0;
			cascade_link_in_oe <= 1'b0;
			multipurpose_pins_o <= '0;
			multipurpose_pins_oe <= 1'b0;
		end else begin
			cascade_link_in_oe <= glob_q[PBC_G_RT];
			multipurpose_pins_oe <= glob_q[PBC_G_RT];
			cascade_link_in_o <= glob_q[PBC_G_RT] ? rec_rt_data[7:0] : 8'h00;
			multipurpose_pins_o <= glob_q[PBC_G_RT] ? rec_rt_data[23:8] : 16'h0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			link_s1_q <= '0;
			link_s2_q <= '0;
		end else begin
			link_s1_q <= cascade_link_in_i;
			link_s2_q <= link_s1_q;
		end
	end

	property p_rec_mode;
		@(posedge mclk) disable iff (rst)
		##1 rec_mode == {$past(glob_q[PBC_G_RFRAME]), $past(glob_q[PBC_G_RSTREAM])};
	endproperty
	a_rec_mode: assert property (p_rec_mode) else $error("record mode decode wrong");

	// Legal size codes pass through unchanged; only the spare code is folded
	property p_rec_size;
		@(posedge mclk) disable iff (rst)
		##1 rec_size != 2'h3 && ($past(glob_q[PBC_G_RSIZE +: 2]) == 2'h3 ||
			rec_size == $past(glob_q[PBC_G_RSIZE +: 2]));
	endproperty
	a_rec_size: assert property (p_rec_size) else $error("record size out of choices");

	property p_hzoom;
		@(posedge mclk) disable iff (rst)
		##1 hzoom_only == $past(glob_q[PBC_G_HZOOM]);
	endproperty
	a_hzoom: assert property (p_hzoom) else $error("horizontal zoom setting lost");

	property p_rt_pins;
		@(posedge mclk) disable iff (rst)
		$rose(glob_q[PBC_G_RT]) |=> cascade_link_in_oe && multipurpose_pins_oe;
	endproperty
	a_rt_pins: assert property (p_rt_pins) else $error("real-time record pins not driven");

	property p_dvr_conv;
		@(posedge mclk) disable iff (rst)
		(ch_dvr_normal_conv | ch_dvr_frame_conv) == '0 ##0
			(chctl_q[0][PBC_C_DVR] ##1 1'b1) |-> ch_vscale_off[0] &&
			(ch_dvr_normal_conv[0] || ch_dvr_frame_conv[0]);
	endproperty
	a_dvr_conv: assert property (p_dvr_conv) else $error("DVR conversion not applied");

	property p_nodvr_noconv;
		@(posedge mclk) disable iff (rst)
		!chctl_q[0][PBC_C_DVR] |=> !ch_dvr_normal_conv[0] && !ch_dvr_frame_conv[0] &&
			!ch_full_image[0];
	endproperty
	a_nodvr_noconv: assert property (p_nodvr_noconv) else $error("conversion without DVR bit");

	property p_apb_wait;
		@(posedge mclk) disable iff (rst)
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");

	c_update: cover property (@(posedge mclk) disable iff (rst) |ch_update);
	c_dvrframe: cover property (@(posedge mclk) disable iff (rst) rec_mode == PBC_REC_DVRFRAME);
	c_rt: cover property (@(posedge mclk) disable iff (rst) cascade_link_in_oe);
endmodule
`default_nettype wire

// ---- rtl/pbc_pkg.sv ----
// Constants, register map and encodings of the playback channel update control.
// Assumes one video clock domain and a 32-bit APB register port.
package pbc_pkg;
	localparam int PBC_NCH = 4;
	localparam int PBC_IDW = 2;

	// Register byte offsets
	localparam logic [7:0] PBC_OFS_GLOBAL = 8'h00;
	localparam logic [7:0] PBC_OFS_CHCTL0 = 8'h04;
	localparam logic [7:0] PBC_OFS_CHSTA0 = 8'h14;
	localparam logic [7:0] PBC_OFS_LINK = 8'h24;
	localparam logic [7:0] PBC_OFS_STEP = 8'h04;

	// Global register fields
	localparam int PBC_G_AUTO = 0;
	localparam int PBC_G_QCROP = 1;
	localparam int PBC_G_HZOOM = 2;
	localparam int PBC_G_RSTREAM = 3;
	localparam int PBC_G_RFRAME = 4;
	localparam int PBC_G_RT = 5;
	localparam int PBC_G_RSIZE = 6;
	localparam int PBC_G_W = 8;
	localparam logic [PBC_G_W-1:0] PBC_G_RST = 8'h00;

	// Channel control register fields
	localparam int PBC_C_MODE = 0;
	localparam int PBC_C_SEL = 2;
	localparam int PBC_C_EVENT = 4;
	localparam int PBC_C_FREEZE = 5;
	localparam int PBC_C_F2F = 6;
	localparam int PBC_C_SPLIT = 7;
	localparam int PBC_C_DVR = 8;
	localparam int PBC_C_PBSRC = 9;
	localparam int PBC_C_HALF = 10;
	localparam int PBC_C_SMALL = 11;
	localparam int PBC_C_W = 12;
	localparam logic [PBC_C_W-1:0] PBC_C_RST = 12'h000;

	// Channel operation modes
	localparam logic [1:0] PBC_MODE_LIVE = 2'h0;
	localparam logic [1:0] PBC_MODE_STROBE = 2'h1;

	// Record modes, {frame select, stream select}
	localparam logic [1:0] PBC_REC_NORMAL = 2'h0;
	localparam logic [1:0] PBC_REC_DVR = 2'h1;
	localparam logic [1:0] PBC_REC_FRAME = 2'h2;
	localparam logic [1:0] PBC_REC_DVRFRAME = 2'h3;

	// Record picture size choices
	localparam logic [1:0] PBC_RSZ_FULL = 2'h0;
	localparam logic [1:0] PBC_RSZ_QUAD = 2'h1;
	localparam logic [1:0] PBC_RSZ_CIF = 2'h2;

	localparam int PBC_CNT_W = 8;

	typedef enum logic [2:0] {
		PBC_ST_LIVE = 3'b001,
		PBC_ST_STROBE = 3'b010,
		PBC_ST_FROZEN = 3'b100
	} pbc_state_t;
endpackage

// ---- rtl/pbc_chan_unit.sv ----
// One display channel's strobe update engine.
// Assumes decoder strobes arrive on mclk, one id_valid pulse per decoded field.
`timescale 1ns/100ps
`default_nettype none
module pbc_chan_unit
	import pbc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic [PBC_IDW-1:0] sel,
	input wire logic auto_en,
	input wire logic event_en,
	input wire logic freeze,
	input wire logic f2f,
	input wire logic id_valid,
	input wire logic [PBC_IDW-1:0] id_ch,
	input wire logic id_event,
	input wire logic id_frame,
	input wire logic id_odd,
	output logic update_q,
	output logic frozen_q,
	output logic [PBC_CNT_W-1:0] count_q
);
	pbc_state_t state_q;
	pbc_state_t state_d;
	logic hit;

	// Frame input with one-field conversion keeps only the odd field to stop shaking
	assign hit = id_valid && (id_ch == sel) && (!(f2f && id_frame) || id_odd) &&
		(event_en ? id_event : auto_en);

	always_comb begin
		state_d = state_q;
		case (state_q)
			PBC_ST_LIVE: begin
				if (mode == PBC_MODE_STROBE) begin
					state_d = freeze ? PBC_ST_FROZEN : PBC_ST_STROBE;
				end
			end
			PBC_ST_STROBE: begin
				if (mode != PBC_MODE_STROBE) begin
					state_d = PBC_ST_LIVE;
				end else if (freeze) begin
					state_d = PBC_ST_FROZEN;
				end
			end
			PBC_ST_FROZEN: begin
				if (mode != PBC_MODE_STROBE) begin
					state_d = PBC_ST_LIVE;
				end else if (!freeze) begin
					state_d = PBC_ST_STROBE;
				end
			end
			default: state_d = PBC_ST_LIVE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= PBC_ST_LIVE;
		end else begin
			state_q <= state_d;
		end
	end

	// Freeze is also checked directly so the cycle of setting it never updates
	always_ff @(posedge mclk) begin
		if (rst) begin
			update_q <= 1'b0;
			count_q <= '0;
		end else begin
			update_q <= (state_q == PBC_ST_STROBE) && !freeze && hit;
			if ((state_q == PBC_ST_STROBE) && !freeze && hit) begin
				count_q <= count_q + PBC_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			frozen_q <= 1'b0;
		end else begin
			frozen_q <= (state_d == PBC_ST_FROZEN);
		end
	end

	property p_freeze_blocks;
		@(posedge mclk) disable iff (rst)
		freeze |=> !update_q;
	endproperty
	a_freeze_blocks: assert property (p_freeze_blocks) else $error("update while frozen");

	property p_strobe_hit;
		@(posedge mclk) disable iff (rst)
		(state_q == PBC_ST_STROBE) && !freeze && id_valid && (id_ch == sel) && auto_en &&
			!event_en && !(f2f && id_frame) |=> update_q;
	endproperty
	a_strobe_hit: assert property (p_strobe_hit) else $error("strobe update missed");

	property p_f2f_even;
		@(posedge mclk) disable iff (rst)
		f2f && id_frame && !id_odd |=> !update_q;
	endproperty
	a_f2f_even: assert property (p_f2f_even) else $error("even field used in one-field mode");

	property p_live_quiet;
		@(posedge mclk) disable iff (rst)
		(state_q == PBC_ST_LIVE) |=> !update_q;
	endproperty
	a_live_quiet: assert property (p_live_quiet) else $error("update in live mode");

	c_resume: cover property (@(posedge mclk) disable iff (rst)
		frozen_q ##1 !frozen_q ##[1:50] update_q);
endmodule
`default_nettype wire

// ---- bench/pbc_recorder_model.sv ----
// Recorder side model: drives the decoded channel ID stream, one strobe per field.
// Assumes a single caller process and the same mclk as the block.
`timescale 1ns/100ps
`default_nettype none
module pbc_recorder_model
	import pbc_pkg::*;
(
	input wire logic mclk,
	output logic id_valid,
	output logic [PBC_IDW-1:0] id_ch,
	output logic id_event,
	output logic id_frame,
	output logic id_odd
);
	initial begin
		id_valid = 1'h0;
		id_ch = 2'h0;
		id_event = 1'h0;
		id_frame = 1'h0;
		id_odd = 1'h0;
	end

	// A gap of 0 keeps the strobe up, so the next field follows in the very next cycle
	task automatic field(input logic [PBC_IDW-1:0] ch, input logic ev, input logic fr,
		input logic od, input int gap);
		@(posedge mclk);
		id_valid <= 1'h1;
		id_ch <= ch;
		id_event <= ev;
		id_frame <= fr;
		id_odd <= od;
		if (gap > 0) begin
			@(posedge mclk);
			id_valid <= 1'h0;
			// Flags mean nothing between strobes; show the inverse so nothing leans on them
			id_ch <= ~ch;
			id_event <= ~ev;
			id_frame <= ~fr;
			id_odd <= ~od;
			repeat (gap - 1) @(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire

// ---- bench/playback_channel_update_ctl_tb_top.sv ----
// Self-checking bench for the playback channel update control.
// Assumes one 25 MHz clock; APB master and field source both driven from here.
`timescale 1ns/100ps
`default_nettype none
module playback_channel_update_ctl_tb_top
	import pbc_pkg::*;
;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, link_i, link_o;
	logic [31:0] pwdata, prdata;
	logic id_valid, id_event, id_frame, id_odd, link_oe, mpp_oe, hzoom_only;
	logic [PBC_IDW-1:0] id_ch;
	logic [23:0] rec_rt_data;
	logic [15:0] mpp_o;
	logic [3:0] ch_update, byp, acrop, froute, dvrn, dvrf, qcrop, vsoff, oddo, fulli;
	logic [1:0] rec_mode, rec_size;
	logic [33:0] rd_q[$];
	logic [3:0] up_q[$];
	logic [33:0] e;
	logic p1 = 1'h0;
	logic p2 = 1'h0;
	int mismatches = 0;
	int checked = 0;

	pbc_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.id_valid(id_valid), .id_ch(id_ch), .id_event(id_event), .id_frame(id_frame),
		.id_odd(id_odd), .rec_rt_data(rec_rt_data), .cascade_link_in_i(link_i),
		.cascade_link_in_o(link_o), .cascade_link_in_oe(link_oe), .multipurpose_pins_o(mpp_o),
		.multipurpose_pins_oe(mpp_oe), .ch_update(ch_update), .ch_bypass(byp),
		.ch_auto_crop(acrop), .ch_field_route(froute), .ch_dvr_normal_conv(dvrn),
		.ch_dvr_frame_conv(dvrf), .ch_quarter_crop(qcrop), .ch_vscale_off(vsoff),
		.ch_odd_only(oddo), .ch_full_image(fulli), .hzoom_only(hzoom_only),
		.rec_mode(rec_mode), .rec_size(rec_size));

	pbc_recorder_model u_rec (.mclk(mclk), .id_valid(id_valid), .id_ch(id_ch),
		.id_event(id_event), .id_frame(id_frame), .id_odd(id_odd));

	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	task automatic results();
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	// For a read, d is the expected data; the monitor compares it at the pready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic err);
		int n;
		rd_q.push_back({~wr, err, d});
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wr ? d : 32'h0;
		@(posedge mclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			results();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic fld(input logic [1:0] ch, input logic ev, input logic fr, input logic od,
		input logic [3:0] exp, input int gap);
		up_q.push_back(exp);
		u_rec.field(ch, ev, fr, od, gap);
	endtask

	task automatic attr(input logic [31:0] g, input logic [31:0] c, input int i,
		input string m);
		logic [8:0] o;
		apb(1'h1, 8'h00, g, 1'h0);
		apb(1'h1, 8'h04, c, 1'h0);
		repeat (3) @(posedge mclk);
		o = {fulli[0], oddo[0], vsoff[0], qcrop[0], dvrf[0], dvrn[0], froute[0], acrop[0], byp[0]};
		chk(o[i], 32'h1, m);
	endtask

	always @(posedge mclk) begin
		p1 <= id_valid;
		p2 <= p1;
		if (pready === 1'h1 && psel && penable) begin
			e = rd_q.pop_front();
			checked++;
			if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
				mismatches++;
				$display("CHECK FAILED %0t apb answer at %h", $time, paddr);
			end
		end
		if (p2) begin
			checked++;
			if (up_q.size() == 0 || ch_update !== up_q.pop_front()) begin
				mismatches++;
				$display("CHECK FAILED %0t channel update %b", $time, ch_update);
			end
		end else if (!rst && ch_update !== 4'h0) begin
			mismatches++;
			$display("CHECK FAILED %0t stray update", $time);
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		results();
	end

	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rec_rt_data = 24'h0;
		link_i = 8'h00;
		void'($urandom(32'h99DD995A));
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		apb(1'h0, 8'h00, 32'h0, 1'h0);
		apb(1'h0, 8'h14, 32'h0, 1'h0);
		apb(1'h0, 8'h30, 32'h0, 1'h1);
		apb(1'h1, 8'h06, 32'hFFF, 1'h1);
		apb(1'h0, 8'h04, 32'h0, 1'h0);
		apb(1'h1, 8'h00, 32'h1, 1'h0);
		apb(1'h1, 8'h04, 32'h209, 1'h0);
		apb(1'h0, 8'h04, 32'h209, 1'h0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h1, 0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h1, 3);
		fld(2'h1, 1'h0, 1'h0, 1'h0, 4'h0, 3);
		apb(1'h1, 8'h04, 32'h229, 1'h0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h0, 3);
		apb(1'h0, 8'h14, 32'h201, 1'h0);
		apb(1'h1, 8'h04, 32'h209, 1'h0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h1, 3);
		apb(1'h1, 8'h04, 32'h219, 1'h0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h0, 3);
		fld(2'h2, 1'h1, 1'h0, 1'h0, 4'h1, 3);
		apb(1'h1, 8'h04, 32'h249, 1'h0);
		fld(2'h2, 1'h0, 1'h1, 1'h0, 4'h0, 3);
		fld(2'h2, 1'h0, 1'h1, 1'h1, 4'h1, 3);
		apb(1'h1, 8'h00, 32'h0, 1'h0);
		apb(1'h1, 8'h04, 32'h209, 1'h0);
		fld(2'h2, 1'h0, 1'h0, 1'h0, 4'h0, 3);
		apb(1'h0, 8'h14, 32'h500, 1'h0);
		apb(1'h1, 8'h08, 32'h200, 1'h0);
		fld(2'h3, 1'h0, 1'h0, 1'h0, 4'h0, 3);
		apb(1'h0, 8'h08, 32'h20C, 1'h0);
		attr(32'h0, 32'h200, 0, "live bypass");
		attr(32'h0, 32'h200, 1, "live auto crop");
		attr(32'h0, 32'h680, 2, "field split routing");
		attr(32'h0, 32'h300, 3, "dvr normal conversion");
		attr(32'h0, 32'h380, 4, "dvr frame conversion");
		attr(32'h2, 32'h300, 5, "quarter crop");
		attr(32'h0, 32'h300, 6, "vertical scaling off");
		attr(32'h0, 32'hB80, 7, "odd lines only");
		attr(32'h4, 32'h300, 8, "full image");
		chk(hzoom_only, 32'h1, "horizontal zoom");
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, 8'h00, i << 3, 1'h0);
			repeat (3) @(posedge mclk);
			chk(rec_mode, i, "record mode");
			apb(1'h1, 8'h00, i << 6, 1'h0);
			repeat (3) @(posedge mclk);
			chk(rec_size, (i == 3) ? 1 : i, "record size");
		end
		rec_rt_data <= 24'($urandom);
		link_i <= 8'($urandom);
		apb(1'h1, 8'h00, 32'h20, 1'h0);
		repeat (4) @(posedge mclk);
		chk({link_oe, mpp_oe, mpp_o, link_o}, {2'h3, rec_rt_data}, "real-time pins");
		apb(1'h0, 8'h24, {24'h0, link_i}, 1'h0);
		apb(1'h1, 8'h00, 32'h0, 1'h0);
		repeat (3) @(posedge mclk);
		chk({link_oe, mpp_oe}, 32'h0, "pins released");
		repeat (4) @(posedge mclk);
		results();
	end
endmodule
`default_nettype wire
